/* File: shared/sram_link_pkg.sv */
// constants shared by both ends of the separate-I/O SRAM link
// assumes nothing beyond a SystemVerilog compiler
package sram_link_pkg;
  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int DATA_W_DEF = 36;
  localparam int ADDR_W_DEF = 21;
  localparam int READ_LAT_DEF = 4;
  localparam int READ_LAT_MIN = 3;
  localparam int LANES = 2;
  localparam int REG_W = 36;
  localparam int REG_AW = 3;
  // ----------------------------------------------------------------
  // controller register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_ADDR = 3'h0;
  localparam logic [2:0] REG_WDATA0 = 3'h1;
  localparam logic [2:0] REG_WDATA1 = 3'h2;
  localparam logic [2:0] REG_CTRL = 3'h3;
  localparam logic [2:0] REG_CFG = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_RDATA0 = 3'h6;
  localparam logic [2:0] REG_RDATA1 = 3'h7;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_START_WR = 0;
  localparam int CTRL_START_RD = 1;
  localparam int CTRL_DEV_RESET = 2;
  localparam logic CTRL_DEV_RESET_RST = 1'b1;
  localparam int CFG_W = 5;
  localparam int CFG_PLL = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_GROUP_LSB = 3;
  localparam logic [4:0] CFG_RST = 5'h01;
  localparam int ST_WR_BUSY = 0;
  localparam int ST_RD_BUSY = 1;
  localparam int ST_RD_DONE = 2;
  // ----------------------------------------------------------------
  // termination strap encodings and the controller write state type
  // ----------------------------------------------------------------
  localparam logic [1:0] TERM_OFF = 2'h0;
  localparam logic [1:0] TERM_STRONG = 2'h1;
  localparam logic [1:0] TERM_WEAK = 2'h2;
  localparam logic [1:0] TERM_RSVD = 2'h3;
  localparam logic [1:0] GRP_WDATA = 2'h0;
  localparam logic [1:0] GRP_CLOCKS = 2'h1;
  localparam logic [1:0] GRP_ADDR_CTL = 2'h2;
  localparam logic [1:0] GRP_ALL = 2'h3;
  typedef enum logic {WR_IDLE, WR_BEAT1} wr_state_t;
endpackage

/* File: shared/sram_link_if.sv */
// pins between the memory controller and the SRAM device port
// assumes the bench resolves pulls on undriven straps and reset
`timescale 1ns/1ps
interface sram_link_if #(
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF,
  parameter int ADDR_W = sram_link_pkg::ADDR_W_DEF
);
  logic link_clk;
  logic rst_pin;
  logic read_sel_n;
  logic write_sel_n;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] write_data;
  logic [sram_link_pkg::LANES-1:0] write_data_clock;
  logic [DATA_W-1:0] read_data;
  logic [sram_link_pkg::LANES-1:0] read_valid_out;
  logic [sram_link_pkg::LANES-1:0] echo_clock_out;
  logic pll_strap;
  logic [1:0] termination_mode_strap;
  logic [1:0] termination_group_strap;
  // controller end
  modport ctrl (
    output link_clk, rst_pin, read_sel_n, write_sel_n, addr_in,
    output write_data, write_data_clock, pll_strap,
    output termination_mode_strap, termination_group_strap,
    input read_data, read_valid_out, echo_clock_out
  );
  // device end
  modport dev (
    input link_clk, rst_pin, read_sel_n, write_sel_n, addr_in,
    input write_data, write_data_clock, pll_strap,
    input termination_mode_strap, termination_group_strap,
    output read_data, read_valid_out, echo_clock_out
  );
endinterface

/* File: src/sram_dev_port.sv */
// device end of the separate-I/O burst-of-two SRAM link
// assumes the controller makes the link clock and holds reset high
// while the link clock starts; the array sits on the user side
// Functional notes
// RL1 - address held on pins for each request
// RL2 - link clock times inputs and all outputs
// RL3 - write data taken on two clock edges
// RL4 - low data bits always, upper only when wide
// RL5 - each write lane latched by its clock
// RL6 - free-running echo clocks aligned with read data
// RL7 - one echo clock per read lane
// RL8 - read valid rises half cycle before data
// RL9 - low read select starts a read
// RL10 - low write select starts a write
// RL11 - PLL strap high enables, pulled high
// RL12 - high reset holds device inactive
// RL13 - mode strap: off, strong, weak, reserved
// RL14 - reset disables PLL, ignores selects
// RL15 - valid low, data idle until first read
// RL16 - group strap picks terminated inputs
// RL17 - two-word bursts, fixed read latency
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sram_dev_port #(
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF,
  parameter int ADDR_W = sram_link_pkg::ADDR_W_DEF,
  parameter int READ_LAT = sram_link_pkg::READ_LAT_DEF
) (
  // link pins
  sram_link_if.dev link,
  // write port toward the array
  output logic mem_wr,
  output logic [ADDR_W-1:0] mem_wr_addr,
  output logic [2*DATA_W-1:0] mem_wr_data,
  // read port toward the array
  output logic mem_rd,
  output logic [ADDR_W-1:0] mem_rd_addr,
  input wire logic [2*DATA_W-1:0] mem_rd_data,
  // decoded straps and state
  output logic pll_enable,
  output logic odt_strong,
  output logic odt_weak,
  output logic odt_on_wdata,
  output logic odt_on_clocks,
  output logic odt_on_addr_ctl,
  output logic odt_mode_reserved,
  output logic dev_active
);
  import sram_link_pkg::*;

  localparam int LW = DATA_W / LANES;
  localparam int BW = 2 * DATA_W;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (DATA_W != 36 && DATA_W != 18) begin : g_bad_width
    $error("data width must be 18 or 36");
  end
  if (READ_LAT < READ_LAT_MIN) begin : g_bad_lat
    $error("read latency too short for the array pipeline");
  end

  // ----------------------------------------------------------------
  // reset pin and strap synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic [4:0] strap_meta_reg;
  logic [4:0] strap_sync_reg;

  // reset pin and straps are board levels, so two flops each
  always_ff @(posedge link.link_clk) begin
    rst_meta_reg <= link.rst_pin;
    rst_sync_reg <= rst_meta_reg;
    strap_meta_reg <= {link.termination_group_strap,
                       link.termination_mode_strap, link.pll_strap};
    strap_sync_reg <= strap_meta_reg;
  end

  // ----------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------
  logic [6:0] odt_reg;
  logic [6:0] odt_next;
  logic [1:0] mode_s;
  logic [1:0] grp_s;
  logic term_on;

  assign mode_s = strap_sync_reg[2:1];
  assign grp_s = strap_sync_reg[4:3];
  assign term_on = (mode_s == TERM_STRONG) || (mode_s == TERM_WEAK);

  // reserved mode is treated as termination off and flagged
  always_comb begin
    odt_next[0] = strap_sync_reg[0] & ~rst_sync_reg; // RL11 RL14
    odt_next[1] = (mode_s == TERM_STRONG); // RL13
    odt_next[2] = (mode_s == TERM_WEAK); // RL13
    odt_next[3] = term_on; // RL16
    odt_next[4] = term_on &&
      ((grp_s == GRP_CLOCKS) || (grp_s == GRP_ALL)); // RL16
    odt_next[5] = term_on &&
      ((grp_s == GRP_ADDR_CTL) || (grp_s == GRP_ALL)); // RL16
    odt_next[6] = (mode_s == TERM_RSVD); // RL13
  end

  always_ff @(posedge link.link_clk) begin
    if (rst_sync_reg) begin
      odt_reg <= 7'h00;
    end else begin
      odt_reg <= odt_next;
    end
  end

  assign pll_enable = odt_reg[0];
  assign odt_strong = odt_reg[1];
  assign odt_weak = odt_reg[2];
  assign odt_on_wdata = odt_reg[3];
  assign odt_on_clocks = odt_reg[4];
  assign odt_on_addr_ctl = odt_reg[5];
  assign odt_mode_reserved = odt_reg[6];
  assign dev_active = ~rst_sync_reg; // RL12

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  logic wr_beat1_reg;
  logic wr_beat1_next;
  logic wr_take;
  logic [DATA_W-1:0] wr_lo_reg;
  logic [DATA_W-1:0] wr_lo_next;
  logic [DATA_W-1:0] wr_hi_reg;
  logic [DATA_W-1:0] wr_hi_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] wr_addr_next;
  logic mem_wr_reg;

  // a select during the second beat belongs to the running burst
  assign wr_take = ~link.write_sel_n & ~rst_sync_reg
                   & ~wr_beat1_reg; // RL10 RL14

  // lanes whose clock is quiet are stored as zero
  always_comb begin
    wr_beat1_next = wr_take;
    wr_lo_next = wr_lo_reg;
    wr_hi_next = wr_hi_reg;
    wr_addr_next = wr_addr_reg;
    if (wr_take) begin
      wr_addr_next = link.addr_in; // RL1
      wr_lo_next = '0;
      for (int i = 0; i < LANES; i++) begin
        if (link.write_data_clock[i]) begin
          wr_lo_next[i*LW +: LW] = link.write_data[i*LW +: LW]; // RL5
        end
      end
    end
    if (wr_beat1_reg) begin
      wr_hi_next = '0;
      for (int i = 0; i < LANES; i++) begin
        if (link.write_data_clock[i]) begin
          wr_hi_next[i*LW +: LW] = link.write_data[i*LW +: LW]; // RL3
        end
      end
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (rst_sync_reg) begin
      wr_beat1_reg <= 1'b0;
      wr_lo_reg <= '0;
      wr_hi_reg <= '0;
      wr_addr_reg <= '0;
      mem_wr_reg <= 1'b0;
    end else begin
      wr_beat1_reg <= wr_beat1_next;
      wr_lo_reg <= wr_lo_next;
      wr_hi_reg <= wr_hi_next;
      wr_addr_reg <= wr_addr_next;
      mem_wr_reg <= wr_beat1_reg; // RL17
    end
  end

  assign mem_wr = mem_wr_reg;
  assign mem_wr_addr = wr_addr_reg;
  assign mem_wr_data = {wr_hi_reg, wr_lo_reg};

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic rd_take;
  logic [READ_LAT:0] rd_shift_reg;
  logic [READ_LAT:0] rd_shift_next;
  logic [BW-1:0] rd_pipe_reg [READ_LAT-2];
  logic [BW-1:0] rd_pipe_next [READ_LAT-2];
  logic [DATA_W-1:0] beat1_reg;
  logic [DATA_W-1:0] beat1_next;
  logic [DATA_W-1:0] q_reg;
  logic [DATA_W-1:0] q_next;
  logic mem_rd_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic valid_reg;
  logic valid_next;

  assign rd_take = ~link.read_sel_n & ~rst_sync_reg
                   & ~rd_shift_reg[0]; // RL9 RL14

  // array answers one cycle after its strobe; the pipe pads the rest
  always_comb begin
    rd_shift_next = {rd_shift_reg[READ_LAT-1:0], rd_take}; // RL17
    rd_pipe_next[0] = mem_rd_data;
    for (int i = 1; i < READ_LAT - 2; i++) begin
      rd_pipe_next[i] = rd_pipe_reg[i-1];
    end
    beat1_next = beat1_reg;
    q_next = '0; // RL15
    if (rd_shift_reg[READ_LAT-1]) begin
      q_next = rd_pipe_reg[READ_LAT-3][DATA_W-1:0]; // RL4
      beat1_next = rd_pipe_reg[READ_LAT-3][BW-1:DATA_W];
    end else if (rd_shift_reg[READ_LAT]) begin
      q_next = beat1_reg; // RL17
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (rst_sync_reg) begin
      rd_shift_reg <= '0;
      beat1_reg <= '0;
      q_reg <= '0;
      mem_rd_reg <= 1'b0;
      rd_addr_reg <= '0;
      for (int i = 0; i < READ_LAT - 2; i++) begin
        rd_pipe_reg[i] <= '0;
      end
    end else begin
      rd_shift_reg <= rd_shift_next;
      beat1_reg <= beat1_next;
      q_reg <= q_next; // RL2
      mem_rd_reg <= rd_take;
      if (rd_take) begin
        rd_addr_reg <= link.addr_in; // RL1
      end
      rd_pipe_reg <= rd_pipe_next;
    end
  end

  assign mem_rd = mem_rd_reg;
  assign mem_rd_addr = rd_addr_reg;
  assign link.read_data = q_reg;

  // ----------------------------------------------------------------
  // read valid, launched on the falling edge
  // ----------------------------------------------------------------
  // valid covers both beats and leads each change by half a cycle
  always_comb begin
    valid_next = rd_shift_reg[READ_LAT-1] | rd_shift_reg[READ_LAT];
  end

  always_ff @(negedge link.link_clk) begin
    if (rst_sync_reg) begin
      valid_reg <= 1'b0; // RL15
    end else begin
      valid_reg <= valid_next; // RL8
    end
  end

  assign link.read_valid_out = {LANES{valid_reg}}; // RL8

  // ----------------------------------------------------------------
  // echo clocks
  // ----------------------------------------------------------------
  // a forwarded copy keeps data edges on echo rising edges
  assign link.echo_clock_out = {LANES{link.link_clk}}; // RL6 RL7
endmodule

/* File: src/sram_ctrl_port.sv */
// controller end of the separate-I/O SRAM link
// assumes software on clk using a plain strobe port, and that the
// device answers on the forwarded link clock
`timescale 1ns/1ps
module sram_ctrl_port #(
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF,
  parameter int ADDR_W = sram_link_pkg::ADDR_W_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // software port
  input wire logic [sram_link_pkg::REG_AW-1:0] reg_addr,
  input wire logic [sram_link_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sram_link_pkg::REG_W-1:0] reg_rdata,
  // link pins
  sram_link_if.ctrl link
);
  import sram_link_pkg::*;

  if (DATA_W > REG_W || ADDR_W > REG_W) begin : g_bad_width
    $error("data or address wider than the register port");
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic lclk_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdat0_reg;
  logic [DATA_W-1:0] wdat1_reg;
  logic dev_rst_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic rd_wait_reg;
  logic rd_done_reg;
  logic beat_reg;
  logic [DATA_W-1:0] rdat0_reg;
  logic [DATA_W-1:0] rdat1_reg;
  wr_state_t wr_state_reg;
  logic rsel_n_reg;
  logic wsel_n_reg;
  logic [ADDR_W-1:0] ain_reg;
  logic [DATA_W-1:0] wd_reg;
  logic [LANES-1:0] wdclk_reg;
  logic [DATA_W-1:0] rq_meta_reg;
  logic [DATA_W-1:0] rq_sync_reg;
  logic vld_meta_reg;
  logic vld_sync_reg;
  logic [REG_W-1:0] rdata_reg;

  logic wr_busy;
  logic rd_busy;
  logic launch;
  logic go_wr;
  logic go_rd;
  logic cap;

  assign wr_busy = wr_pend_reg | (wr_state_reg != WR_IDLE);
  assign rd_busy = rd_pend_reg | rd_wait_reg;
  // outputs change as the link clock falls, stable at its rise
  assign launch = lclk_reg;
  assign go_wr = reg_wr && reg_addr == REG_CTRL
                 && reg_wdata[CTRL_START_WR] && !wr_busy;
  assign go_rd = reg_wr && reg_addr == REG_CTRL
                 && reg_wdata[CTRL_START_RD] && !rd_busy;
  assign cap = launch & vld_sync_reg;

  // ----------------------------------------------------------------
  // read data synchroniser
  // ----------------------------------------------------------------
  // only lane 0 valid is watched; both lanes move together
  always_ff @(posedge clk) begin
    rq_meta_reg <= link.read_data;
    rq_sync_reg <= rq_meta_reg;
    vld_meta_reg <= link.read_valid_out[0];
    vld_sync_reg <= vld_meta_reg;
  end

  // ----------------------------------------------------------------
  // software registers and request sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lclk_reg <= 1'b0;
      addr_reg <= '0;
      wdat0_reg <= '0;
      wdat1_reg <= '0;
      dev_rst_reg <= CTRL_DEV_RESET_RST;
      cfg_reg <= CFG_RST;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      beat_reg <= 1'b0;
      rdat0_reg <= '0;
      rdat1_reg <= '0;
      wr_state_reg <= WR_IDLE;
      rsel_n_reg <= 1'b1;
      wsel_n_reg <= 1'b1;
      ain_reg <= '0;
      wd_reg <= '0;
      wdclk_reg <= '0;
      rdata_reg <= '0;
    end else begin
      lclk_reg <= ~lclk_reg;
      // software writes; a start while busy is dropped
      if (reg_wr) begin
        unique case (reg_addr)
          REG_ADDR: addr_reg <= reg_wdata[ADDR_W-1:0];
          REG_WDATA0: wdat0_reg <= reg_wdata[DATA_W-1:0];
          REG_WDATA1: wdat1_reg <= reg_wdata[DATA_W-1:0];
          REG_CTRL: dev_rst_reg <= reg_wdata[CTRL_DEV_RESET];
          REG_CFG: cfg_reg <= reg_wdata[CFG_W-1:0];
          default: ;
        endcase
      end
      if (go_wr) begin
        wr_pend_reg <= 1'b1; // RL10
      end
      if (go_rd) begin
        rd_pend_reg <= 1'b1; // RL9
        rd_done_reg <= 1'b0;
      end
      // launch slot: selects and address for the next rising edge
      if (launch) begin
        rsel_n_reg <= ~rd_pend_reg; // RL9
        if (rd_pend_reg) begin
          rd_pend_reg <= 1'b0;
          rd_wait_reg <= 1'b1;
          beat_reg <= 1'b0;
        end
        if (rd_pend_reg || (wr_pend_reg && wr_state_reg == WR_IDLE)) begin
          ain_reg <= addr_reg; // RL1
        end
        unique case (wr_state_reg)
          WR_IDLE: begin
            wsel_n_reg <= ~wr_pend_reg; // RL10
            wdclk_reg <= {LANES{wr_pend_reg}};
            if (wr_pend_reg) begin
              wd_reg <= wdat0_reg; // RL3
              wr_pend_reg <= 1'b0;
              wr_state_reg <= WR_BEAT1;
            end
          end
          WR_BEAT1: begin
            wsel_n_reg <= 1'b1;
            wd_reg <= wdat1_reg; // RL3 RL17
            wdclk_reg <= {LANES{1'b1}}; // RL5
            wr_state_reg <= WR_IDLE;
          end
        endcase
      end
      // two beats per read, then done; the set is last so it wins
      if (cap && rd_wait_reg) begin
        beat_reg <= ~beat_reg;
        if (!beat_reg) begin
          rdat0_reg <= rq_sync_reg; // RL17
        end else begin
          rdat1_reg <= rq_sync_reg;
          rd_wait_reg <= 1'b0;
          rd_done_reg <= 1'b1;
        end
      end
      // read data stand one cycle only
      rdata_reg <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_ADDR: rdata_reg <= REG_W'(addr_reg);
          REG_WDATA0: rdata_reg <= REG_W'(wdat0_reg);
          REG_WDATA1: rdata_reg <= REG_W'(wdat1_reg);
          REG_CTRL: rdata_reg <= REG_W'({dev_rst_reg, 2'b00});
          REG_CFG: rdata_reg <= REG_W'(cfg_reg);
          REG_STATUS: rdata_reg <=
            REG_W'({rd_done_reg, rd_busy, wr_busy});
          REG_RDATA0: rdata_reg <= REG_W'(rdat0_reg);
          REG_RDATA1: rdata_reg <= REG_W'(rdat1_reg);
        endcase
      end
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  assign link.link_clk = lclk_reg;
  assign link.rst_pin = dev_rst_reg; // RL12
  assign link.read_sel_n = rsel_n_reg;
  assign link.write_sel_n = wsel_n_reg;
  assign link.addr_in = ain_reg;
  assign link.write_data = wd_reg;
  assign link.write_data_clock = wdclk_reg;
  assign link.pll_strap = cfg_reg[CFG_PLL]; // RL11
  assign link.termination_mode_strap = cfg_reg[CFG_MODE_LSB +: 2];
  assign link.termination_group_strap = cfg_reg[CFG_GROUP_LSB +: 2];
endmodule

/* File: test/sram_link_sva.sv */
// checker for the link pins between the controller and device ends
// assumes it sits beside the interface and sees its signals as inputs
`timescale 1ns/1ps
module sram_link_sva #(
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF,
  parameter int READ_LAT = sram_link_pkg::READ_LAT_DEF
) (
  // link clock and device reset
  input wire logic link_clk,
  input wire logic rst_pin,
  // selects and write side
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [1:0] write_data_clock,
  // read side
  input wire logic [DATA_W-1:0] read_data,
  input wire logic [1:0] read_valid_out,
  input wire logic [1:0] echo_clock_out
);
  import sram_link_pkg::*;
  localparam int LEAD = READ_LAT - 1;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic act;
  // ----------------------------------------------------------------
  // reset view
  // ----------------------------------------------------------------
  // two-flop copy of reset, so selects in the sync window are not taken
  always_comb sync_next = {sync_reg[0], rst_pin};
  always_ff @(posedge link_clk) sync_reg <= sync_next;
  assign act = !sync_reg[1];
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst_pin);
  // ----------------------------------------------------------------
  // sequences and assertions
  // ----------------------------------------------------------------
  sequence rd_take;
    !read_sel_n && act;
  endsequence
  // valid leads data by half a cycle, so data is still idle at its edge
  sequence valid_win;
    read_valid_out == 2'h3 && read_data == '0 ##1 read_valid_out == 2'h3;
  endsequence
  sequence wr_beats;
    write_data_clock == 2'h3 [*2];
  endsequence
  a_read_latency: assert property (
    rd_take |-> ##LEAD read_valid_out == 2'h0 ##1 valid_win
    ##1 read_valid_out == 2'h0 ##1 read_data == '0)
    else $error("read valid or data off its latency slot");
  a_data_after_valid: assert property (
    (read_data != '0) |-> $past(read_valid_out) == 2'h3)
    else $error("read data shown without valid ahead of it");
  a_valid_lanes: assert property (
    read_valid_out[0] == read_valid_out[1])
    else $error("read valid lanes differ");
  a_echo_running: assert property (
    @(negedge link_clk) act |-> echo_clock_out == 2'h3)
    else $error("echo clocks not following the link clock");
  a_reset_quiet: assert property (
    $fell(rst_pin) |-> (read_valid_out == 2'h0 && read_data == '0) [*2])
    else $error("read outputs not idle out of reset");
  a_rsel_pulse: assert property (
    !read_sel_n |=> read_sel_n)
    else $error("read select low longer than one cycle");
  a_wsel_pulse: assert property (
    !write_sel_n |=> write_sel_n)
    else $error("write select low longer than one cycle");
  a_write_burst: assert property (
    !write_sel_n |-> wr_beats ##1 write_data_clock == 2'h0)
    else $error("write lane marks not two beats long");
  a_wdclk_in_burst: assert property (
    (write_data_clock != 2'h0) |->
      (!write_sel_n || $past(write_sel_n) == 1'h0))
    else $error("write lane mark outside a write burst");
endmodule

/* File: test/testbench.sv */
// self-checking bench joining controller and device ends of the link
// assumes the controller makes the link clock; bench models the array
`timescale 1ns/1ps
module testbench;
  import sram_link_pkg::*;
  localparam int DW = DATA_W_DEF;
  localparam int AW = ADDR_W_DEF;
  logic clk, resetn, reg_wr, reg_rd, note, rdv, nv, dev_active;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_W-1:0] reg_wdata, reg_rdata, last;
  logic mem_wr, mem_rd;
  logic [AW-1:0] mem_wr_addr, mem_rd_addr, ea;
  logic [2*DW-1:0] mem_wr_data, mem_rd_data, ed;
  logic [2*DW-1:0] mem [logic [AW-1:0]];
  wire logic [6:0] straps;
  logic [1:0] m, g;
  logic p, on;
  logic [6:0] want;
  logic [63:0] r0, r1;
  logic [31:0] seed;
  logic [REG_W-1:0] exp_q[$];
  int failures, checks, wr_cnt, wr_exp;
  sram_link_if #(.DATA_W(DW), .ADDR_W(AW)) i_sram_link_if ();
  sram_ctrl_port #(.DATA_W(DW), .ADDR_W(AW)) i_sram_ctrl_port (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(i_sram_link_if));
  sram_dev_port #(.DATA_W(DW), .ADDR_W(AW), .READ_LAT(READ_LAT_DEF))
    i_sram_dev_port (.link(i_sram_link_if), .mem_wr(mem_wr),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_rd(mem_rd),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .pll_enable(straps[6]), .odt_strong(straps[5]), .odt_weak(straps[4]),
    .odt_on_wdata(straps[3]), .odt_on_clocks(straps[2]),
    .odt_on_addr_ctl(straps[1]), .odt_mode_reserved(straps[0]),
    .dev_active(dev_active));
  sram_link_sva #(.DATA_W(DW), .READ_LAT(READ_LAT_DEF)) chk_link (
    .link_clk(i_sram_link_if.link_clk), .rst_pin(i_sram_link_if.rst_pin),
    .read_sel_n(i_sram_link_if.read_sel_n),
    .write_sel_n(i_sram_link_if.write_sel_n),
    .write_data_clock(i_sram_link_if.write_data_clock),
    .read_data(i_sram_link_if.read_data),
    .read_valid_out(i_sram_link_if.read_valid_out),
    .echo_clock_out(i_sram_link_if.echo_clock_out));
  initial clk = 1'h0;
  always #20 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one-cycle strobes; a spare edge between calls keeps drivers apart
  task automatic wr(input logic [2:0] a, input logic [35:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, input logic chk, logic [35:0] e);
    @(posedge clk);
    if (chk) exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    note <= chk;
    @(posedge clk);
    reg_rd <= 1'h0;
    note <= 1'h0;
  endtask
  task automatic wait_idle(input int b);
    int n;
    n = 0;
    do begin
      rd(REG_STATUS, 1'h0, 36'h0);
      @(posedge clk);
      #1;
      n++;
    end while (last[b] !== 1'h0 && n < 100);
    check(last[b], 1'h0);
  endtask
  task automatic settle(input logic [6:0] w);
    int n;
    n = 0;
    while (straps !== w && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(straps, w);
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rdv <= reg_rd;
    nv <= reg_rd & note;
    if (rdv) last <= reg_rdata;
    if (nv) check(reg_rdata, exp_q.pop_front());
  end
  // array model: idle read data flips so stale values never match
  always @(posedge i_sram_link_if.link_clk) begin
    if (mem_wr === 1'h1) begin
      wr_cnt++;
      mem[mem_wr_addr] = mem_wr_data;
      check({mem_wr_addr, mem_wr_data}, {ea, ed});
    end
    if (mem_rd === 1'h1) mem_rd_data <= mem[mem_rd_addr];
    else mem_rd_data <= ~mem_rd_data;
  end
  initial begin
    #400000;
    failures++;
    report_and_stop;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'h0;
    reg_addr = 3'h0;
    reg_wdata = 36'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    note = 1'h0;
    mem_rd_data = 72'h0;
    seed = 32'h9A51F51B;
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    rd(REG_CTRL, 1'h1, 36'h4);
    rd(REG_CFG, 1'h1, 36'h1);
    wr(REG_STATUS, 36'hF);
    rd(REG_STATUS, 1'h1, 36'h0);
    settle(7'h00);
    check(dev_active, 1'h0);
    wr(REG_CTRL, 36'h0);
    // every mode and group, pll strap toggled along the way
    for (int i = 0; i < 16; i++) begin
      m = 2'(i);
      g = 2'(i >> 2);
      p = m[0] ^ g[0];
      wr(REG_CFG, {31'h0, g, m, p});
      rd(REG_CFG, 1'h1, {31'h0, g, m, p});
      on = (m == TERM_STRONG) || (m == TERM_WEAK);
      want = {p, m == TERM_STRONG, m == TERM_WEAK, on, on & g[0], on & g[1],
        m == TERM_RSVD};
      settle(want);
    end
    // random bursts written then read back; first start is sent twice
    for (int i = 0; i < 6; i++) begin
      r0 = {xs(), xs()};
      r1 = {xs(), xs()};
      ea = r0[63:43];
      ed = {r1[35:0], r0[35:0]};
      wr(REG_ADDR, {15'h0, ea});
      wr(REG_WDATA0, r0[35:0]);
      wr(REG_WDATA1, r1[35:0]);
      wr(REG_CTRL, 36'h1);
      if (i == 0) wr(REG_CTRL, 36'h1);
      wr_exp++;
      wait_idle(ST_WR_BUSY);
      wr(REG_CTRL, 36'h2);
      wait_idle(ST_RD_BUSY);
      rd(REG_RDATA0, 1'h1, r0[35:0]);
      rd(REG_RDATA1, 1'h1, r1[35:0]);
      rd(REG_STATUS, 1'h1, 36'h4);
    end
    check(wr_cnt, wr_exp);
    // device reset in mid-run, then a read of the last burst
    wr(REG_CTRL, 36'h4);
    settle(7'h00);
    check(dev_active, 1'h0);
    wr(REG_CTRL, 36'h0);
    repeat (8) @(posedge clk);
    settle(7'h01);
    wr(REG_CTRL, 36'h2);
    wait_idle(ST_RD_BUSY);
    rd(REG_RDATA1, 1'h1, r1[35:0]);
    report_and_stop;
  end
endmodule
